// ===== common/sps_pkg.sv
// Package with register map, field layout, reset values and shared decode functions.
package sps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  SPS_OFF_CTRL      = 8'h00;
    localparam logic [7:0]  SPS_OFF_DIVIDE    = 8'h04;
    localparam logic [7:0]  SPS_OFF_SEED      = 8'h08;
    localparam logic [7:0]  SPS_OFF_NUMER     = 8'h0c;
    localparam logic [7:0]  SPS_OFF_DENOM     = 8'h10;
    localparam logic [7:0]  SPS_OFF_DELAY     = 8'h14;
    localparam logic [7:0]  SPS_OFF_TRIM      = 8'h18;
    localparam logic [7:0]  SPS_OFF_STATUS    = 8'h1c;
    localparam logic [7:0]  SPS_OFF_CAL_FORCE = 8'h20;
    localparam logic [7:0]  SPS_OFF_CAL_READ  = 8'h24;
    localparam logic [7:0]  SPS_OFF_CMD       = 8'h28;
    localparam logic [7:0]  SPS_OFF_PHASE     = 8'h2c;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          SPS_CTRL_SYNC_EN   = 0;
    localparam int          SPS_CTRL_PIN_IGN   = 1;
    localparam int          SPS_CTRL_OUTA_LSB  = 2;
    localparam int          SPS_CTRL_OUTB_LSB  = 4;
    localparam int          SPS_CTRL_PULSE_EN  = 6;
    localparam int          SPS_CTRL_PULSED    = 7;
    localparam int          SPS_CTRL_COUNT_LSB = 8;
    localparam int          SPS_CTRL_ORDER_LSB = 12;
    localparam int          SPS_CMD_MOD_RST    = 0;
    localparam int          SPS_CMD_START      = 1;
    localparam int          SPS_CAL_FORCE_BIT  = 0;
    localparam int          SPS_CAL_CORE_LSB   = 8;
    localparam int          SPS_CAL_CAP_LSB    = 16;
    localparam int          SPS_CAL_CUR_LSB    = 24;
    localparam int          SPS_ST_FOLD_LSB    = 4;
    localparam int          SPS_ST_COUNT_LSB   = 8;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] SPS_CTRL_RST   = 32'h0000_0402;
    localparam logic [31:0] SPS_DIVIDE_RST = 32'h0000_0002;
    localparam logic [31:0] SPS_DENOM_RST  = 32'h0000_0001;

    localparam logic [1:0]  SPS_SEL_CHANNEL_DIVIDE_VALUE = 2'h0;
    localparam logic [1:0]  SPS_SEL_OSC   = 2'h1;
    localparam logic [1:0]  SPS_SEL_PULSE = 2'h2;

    localparam logic [7:0]  SPS_CHANNEL_DIVIDE_VALUE_SKIP_A = 8'h18;
    localparam logic [7:0]  SPS_CHANNEL_DIVIDE_VALUE_SKIP_B = 8'hc0;
    localparam logic [7:0]  SPS_SEG_BY_THREE = 8'h03;
    localparam logic [2:0]  SPS_SEG_THREE    = 3'h3;
    localparam logic [2:0]  SPS_SEG_TWO      = 3'h2;
    localparam logic [2:0]  SPS_FOLD_NONE    = 3'h1;

    localparam logic [7:0]  SPS_TRIM_START_ONE = 8'h24;
    localparam logic [7:0]  SPS_TRIM_START_TWO = 8'h1b;
    localparam logic [7:0]  SPS_TRIM_SUM       = 8'h3f;
    localparam logic [7:0]  SPS_DELAY_MAX      = 8'hf7;

    ////////////////////////////////////////////////////////////////////////////
    // Second channel-divider segment: three for divides by three except 24 and 192, else two.
    function automatic logic [2:0] sps_segment_two(input logic [7:0] channel_divide_value);
        if ((channel_divide_value % SPS_SEG_BY_THREE) == 8'h00 && channel_divide_value != SPS_CHANNEL_DIVIDE_VALUE_SKIP_A && channel_divide_value != SPS_CHANNEL_DIVIDE_VALUE_SKIP_B) begin
            return SPS_SEG_THREE;
        end
        return SPS_SEG_TWO;
    endfunction : sps_segment_two

    // Divide value that the feedback path absorbs in sync mode.
    function automatic logic [2:0] sps_folded(input logic [1:0] sel_a,
                                              input logic [1:0] sel_b,
                                              input logic [7:0] channel_divide_value);
        logic [2:0] seg;
        seg = sps_segment_two(channel_divide_value);
        if (sel_a != SPS_SEL_CHANNEL_DIVIDE_VALUE && sel_b != SPS_SEL_CHANNEL_DIVIDE_VALUE && sel_b != SPS_SEL_PULSE) begin
            return SPS_FOLD_NONE;
        end
        return {seg[1:0], 1'b0};
    endfunction : sps_folded

endpackage : sps_pkg

// ===== logic/sps_phase_sync.sv
// Phase sync, seed phase shift and reference-pulse control with APB registers.
//
// Function
// - Folded divide is 1 when neither output uses the channel divider; the code also requires output B not on the pulse source.
// - Otherwise folded divide is twice the second divider segment.
// - Entering sync mode by setting enable is not itself a sync event.
// - Sync fires on enable going 0 to 1 or a sync pin rising edge.
// - Sync or modulator reset returns the seed phase shift to zero.
// - Each seed write adds its phase shift to the current phase.
// - Shift is 360 times seed over denominator times folded over channel divide; the code adds seed times folded divide only.
// - Reference pulses only run while sync mode is enabled.
// - Reference pulses follow the output as single, burst or continuous stream.
// - Delay setting maps onto four trim words; above 247 is invalid.
// - Calibration choices can be read back and forced on later calibrations.
// - A sync request is retimed to the next reference oscillator rising edge.
// - Where folded divide is not 1, it is 6 for divides by three except 24 and 192, else 4.
// - Pulsed mode emits the pulse-count number of pulses, 0 to 15.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
module sps_phase_sync
    import sps_pkg::*;
#(
    parameter int ADDR_W  = 8,
    parameter int PHASE_W = 40
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sync_pin,
    input  wire logic              osc_edge,
    input  wire logic              output_tick,
    input  wire logic              pulse_request,
    input  wire logic [2:0]        cal_core_in,
    input  wire logic [7:0]        cal_capcode_in,
    input  wire logic [7:0]        osc_current_setting_in,
    output logic                   sync_event,
    output logic                   modulator_reset,
    output logic [31:0]            modulator_seed,
    output logic [2:0]             folded_divide,
    output logic                   pulse_out,
    output logic [5:0]             delay_trim_one,
    output logic [5:0]             delay_trim_two,
    output logic [5:0]             delay_trim_three,
    output logic [5:0]             delay_trim_four,
    output logic                   cal_force,
    output logic [2:0]             cal_core_out,
    output logic [7:0]             cal_capcode_out,
    output logic [7:0]             osc_current_setting_out
);

    if (ADDR_W < 8 || PHASE_W < 35) begin : g_bad_param
        $error("sps_phase_sync: ADDR_W must be at least 8 and PHASE_W at least 35.");
    end

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_HIGH = 2'b01,
        PS_LOW  = 2'b10
    } sps_pulse_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and APB slave.
    logic [31:0]        ctrl_q, ctrl_d;
    logic [31:0]        divide_q, divide_d;
    logic [31:0]        seed_q, seed_d;
    logic [31:0]        numer_q, numer_d;
    logic [31:0]        denom_q, denom_d;
    logic [7:0]         delay_q, delay_d;
    logic [31:0]        calf_q, calf_d;
    logic [31:0]        prdata_q, prdata_d;
    logic               pready_q, pready_d;
    logic               pslverr_q, pslverr_d;
    logic [PHASE_W-1:0] phase_q;
    logic [7:0]         sync_count_q;
    logic               pulse_busy;
    logic [5:0]         trim1, trim2, trim3, trim4;
    logic               delay_bad;
    logic [7:0]         addr;
    logic               setup;
    logic               wr;
    logic               known;

    assign addr  = paddr[7:0];
    assign setup = psel && !penable;
    assign wr    = psel && penable && pwrite && pready_q && !pslverr_q;

    always_comb begin
        known = 1'b1;
        case (addr)
            SPS_OFF_CTRL, SPS_OFF_DIVIDE, SPS_OFF_SEED, SPS_OFF_NUMER, SPS_OFF_DENOM, SPS_OFF_DELAY,
            SPS_OFF_TRIM, SPS_OFF_STATUS, SPS_OFF_CAL_FORCE, SPS_OFF_CAL_READ, SPS_OFF_CMD,
            SPS_OFF_PHASE: known = ((paddr >> 8) == '0);
            default: known = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_d    = ctrl_q;
        divide_d  = divide_q;
        seed_d    = seed_q;
        numer_d   = numer_q;
        denom_d   = denom_q;
        delay_d   = delay_q;
        calf_d    = calf_q;
        pready_d  = setup;
        pslverr_d = setup && !known;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (addr)
                SPS_OFF_CTRL:      prdata_d = ctrl_q;
                SPS_OFF_DIVIDE:    prdata_d = divide_q;
                SPS_OFF_SEED:      prdata_d = seed_q;
                SPS_OFF_NUMER:     prdata_d = numer_q;
                SPS_OFF_DENOM:     prdata_d = denom_q;
                SPS_OFF_DELAY:     prdata_d = {24'h000000, delay_q};
                SPS_OFF_TRIM:      prdata_d = {2'h0, trim4, 2'h0, trim3, 2'h0, trim2, 2'h0, trim1};
                SPS_OFF_STATUS:    prdata_d = {16'h0000, sync_count_q, 1'b0, folded_divide, 1'b0,
                                               delay_bad, pulse_busy, ctrl_q[SPS_CTRL_SYNC_EN]};
                SPS_OFF_CAL_FORCE: prdata_d = calf_q;
                SPS_OFF_CAL_READ:  prdata_d = {osc_current_setting_in, cal_capcode_in, 5'h00, cal_core_in,
                                               8'h00};
                SPS_OFF_PHASE:     prdata_d = phase_q[31:0];
                default:           prdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (addr)
                SPS_OFF_CTRL:      ctrl_d   = pwdata;
                SPS_OFF_DIVIDE:    divide_d = {24'h000000, pwdata[7:0]};
                SPS_OFF_SEED:      seed_d   = pwdata;
                SPS_OFF_NUMER:     numer_d  = pwdata;
                SPS_OFF_DENOM:     denom_d  = pwdata;
                SPS_OFF_DELAY:     delay_d  = pwdata[7:0];
                SPS_OFF_CAL_FORCE: calf_d   = pwdata;
                default:           ctrl_d   = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= SPS_CTRL_RST;
            divide_q  <= SPS_DIVIDE_RST;
            seed_q    <= 32'h0000_0000;
            numer_q   <= 32'h0000_0000;
            denom_q   <= SPS_DENOM_RST;
            delay_q   <= 8'h00;
            calf_q    <= 32'h0000_0000;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            divide_q  <= divide_d;
            seed_q    <= seed_d;
            numer_q   <= numer_d;
            denom_q   <= denom_d;
            delay_q   <= delay_d;
            calf_q    <= calf_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign modulator_seed          = seed_q;
    assign cal_force               = calf_q[SPS_CAL_FORCE_BIT];
    assign cal_core_out            = calf_q[SPS_CAL_CORE_LSB +: 3];
    assign cal_capcode_out         = calf_q[SPS_CAL_CAP_LSB +: 8];
    assign osc_current_setting_out = calf_q[SPS_CAL_CUR_LSB +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // Sync request capture, retiming and seed phase accumulation.
    logic               entered_q, entered_d;
    logic               pin_prev_q, pin_prev_d;
    logic               pending_q, pending_d;
    logic               event_q, event_d;
    logic               mrst_q, mrst_d;
    logic [7:0]         sync_count_d;
    logic [2:0]         fold_q, fold_d;
    logic [PHASE_W-1:0] phase_d;
    logic               sw_sync;
    logic               pin_sync;
    logic [34:0]        seed_step;

    always_comb begin
        fold_d = sps_folded(ctrl_q[SPS_CTRL_OUTA_LSB +: 2], ctrl_q[SPS_CTRL_OUTB_LSB +: 2], divide_q[7:0]);
        entered_d  = entered_q || ctrl_q[SPS_CTRL_SYNC_EN];
        pin_prev_d = sync_pin;
        sw_sync  = wr && (addr == SPS_OFF_CTRL) && pwdata[SPS_CTRL_SYNC_EN] && !ctrl_q[SPS_CTRL_SYNC_EN]
                   && entered_q;
        pin_sync = sync_pin && !pin_prev_q && ctrl_q[SPS_CTRL_SYNC_EN] && !ctrl_q[SPS_CTRL_PIN_IGN];
        pending_d = (pending_q && !osc_edge) || sw_sync || pin_sync;
        event_d   = pending_q && osc_edge;
        sync_count_d = event_q ? sync_count_q + 8'h01 : sync_count_q;
        mrst_d = wr && (addr == SPS_OFF_CMD) && pwdata[SPS_CMD_MOD_RST];
        // seed step scaled by folded divide
        seed_step = seed_d * fold_q;
        phase_d = (event_q || mrst_q) ? '0 : phase_q;
        if (wr && (addr == SPS_OFF_SEED)) begin
            phase_d = phase_d + PHASE_W'(seed_step);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fold_q       <= SPS_FOLD_NONE;
            entered_q    <= 1'b0;
            pin_prev_q   <= 1'b0;
            pending_q    <= 1'b0;
            event_q      <= 1'b0;
            mrst_q       <= 1'b0;
            sync_count_q <= 8'h00;
            phase_q      <= '0;
        end else begin
            fold_q       <= fold_d;
            entered_q    <= entered_d;
            pin_prev_q   <= pin_prev_d;
            pending_q    <= pending_d;
            event_q      <= event_d;
            mrst_q       <= mrst_d;
            sync_count_q <= sync_count_d;
            phase_q      <= phase_d;
        end
    end

    assign sync_event      = event_q;
    assign modulator_reset = mrst_q;
    assign folded_divide   = fold_q;

    ////////////////////////////////////////////////////////////////////////////
    // Reference pulse generator.
    sps_pulse_state_t pst_q, pst_d;
    logic [3:0]       left_q, left_d;
    logic             req_prev_q;
    logic             pout_q, pout_d;
    logic             active;
    logic             burst;
    logic             more;
    logic             start;

    always_comb begin
        active = ctrl_q[SPS_CTRL_SYNC_EN] && ctrl_q[SPS_CTRL_PULSE_EN];
        burst  = ctrl_q[SPS_CTRL_PULSED];
        start  = burst && ((pulse_request && !req_prev_q) ||
                           (wr && (addr == SPS_OFF_CMD) && pwdata[SPS_CMD_START]));
        more   = burst ? (left_q != 4'h0) : pulse_request;
        pst_d  = pst_q;
        left_d = left_q;
        if (!active) begin
            pst_d  = PS_IDLE;
            left_d = 4'h0;
        end else begin
            case (pst_q)
                PS_IDLE: begin
                    if (start) begin
                        left_d = ctrl_q[SPS_CTRL_COUNT_LSB +: 4];
                    end else if (output_tick && more) begin
                        pst_d  = PS_HIGH;
                        left_d = burst ? left_q - 4'h1 : left_q;
                    end
                end
                PS_HIGH: begin
                    if (output_tick) begin
                        pst_d = PS_LOW;
                    end
                end
                PS_LOW: begin
                    if (output_tick) begin
                        pst_d  = more ? PS_HIGH : PS_IDLE;
                        left_d = (more && burst) ? left_q - 4'h1 : left_q;
                    end
                end
                default: pst_d = PS_IDLE;
            endcase
        end
        pout_d     = (pst_d == PS_HIGH);
        pulse_busy = (pst_q != PS_IDLE) || (left_q != 4'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_q      <= PS_IDLE;
            left_q     <= 4'h0;
            req_prev_q <= 1'b0;
            pout_q     <= 1'b0;
        end else begin
            pst_q      <= pst_d;
            left_q     <= left_d;
            req_prev_q <= pulse_request;
            pout_q     <= pout_d;
        end
    end

    assign pulse_out = pout_q;

    ////////////////////////////////////////////////////////////////////////////
    // delay setting to trim words
    sps_trim_table u_trim (
        .pclk       (pclk),
        .presetn    (presetn),
        .setting    (delay_q),
        .trim_one   (trim1),
        .trim_two   (trim2),
        .trim_three (trim3),
        .trim_four  (trim4),
        .invalid    (delay_bad)
    );

    assign delay_trim_one   = trim1;
    assign delay_trim_two   = trim2;
    assign delay_trim_three = trim3;
    assign delay_trim_four  = trim4;

endmodule : sps_phase_sync

// ===== logic/sps_trim_table.sv
// Lookup of the four delay trim words from the concatenated delay setting.
`timescale 1ns/100ps
module sps_trim_table
    import sps_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] setting,
    output logic      [5:0] trim_one,
    output logic      [5:0] trim_two,
    output logic      [5:0] trim_three,
    output logic      [5:0] trim_four,
    output logic            invalid
);

    ////////////////////////////////////////////////////////////////////////////
    // Each step moves one count from the current trim word to the next one.
    function automatic logic [24:0] trim_of(input logic [7:0] s);
        logic [7:0] e1;
        logic [7:0] e2;
        logic [7:0] e3;
        logic [7:0] e4;
        logic [7:0] k;
        logic [7:0] t1;
        logic [7:0] t2;
        logic [7:0] t3;
        logic [7:0] t4;
        e1 = SPS_TRIM_START_ONE;
        e2 = e1 + SPS_TRIM_SUM;
        e3 = e2 + SPS_TRIM_SUM;
        e4 = e3 + SPS_TRIM_SUM;
        t1 = 8'h00;
        t2 = 8'h00;
        t3 = 8'h00;
        t4 = 8'h00;
        k  = 8'h00;
        if (s <= e1) begin
            t1 = e1 - s;
            t2 = SPS_TRIM_START_TWO + s;
        end else if (s <= e2) begin
            k  = s - e1;
            t2 = SPS_TRIM_SUM - k;
            t3 = k;
        end else if (s <= e3) begin
            k  = s - e2;
            t3 = SPS_TRIM_SUM - k;
            t4 = k;
        end else if (s <= e4) begin
            k  = s - e3;
            t4 = SPS_TRIM_SUM - k;
            t1 = k;
        end else if (s <= SPS_DELAY_MAX) begin
            k  = s - e4;
            t1 = SPS_TRIM_SUM - k;
            t2 = k;
        end
        return {(s > SPS_DELAY_MAX), t4[5:0], t3[5:0], t2[5:0], t1[5:0]};
    endfunction : trim_of

    logic [24:0] word_d;
    logic [24:0] word_q;

    always_comb begin
        word_d = trim_of(setting);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q <= 25'h0000000;
        end else begin
            word_q <= word_d;
        end
    end

    assign trim_one   = word_q[5:0];
    assign trim_two   = word_q[11:6];
    assign trim_three = word_q[17:12];
    assign trim_four  = word_q[23:18];
    assign invalid    = word_q[24];

endmodule : sps_trim_table

// ===== testbench/sps_ctrl_model.sv
// Model of the system controller: reference edges, output ticks and the sync pin.
`timescale 1ns/100ps
module sps_ctrl_model (
    input wire logic pclk, presetn, sync_req,
    output logic     osc_edge, output_tick, sync_pin
);
    logic [1:0] osc_cnt_q;
    logic [1:0] tick_cnt_q;
    assign osc_edge = (osc_cnt_q == 2'h2);
    assign output_tick = (tick_cnt_q == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 2'h0;
            tick_cnt_q <= 2'h0;
            sync_pin <= 1'h0;
        end else begin
            osc_cnt_q <= (osc_cnt_q == 2'h2) ? 2'h0 : osc_cnt_q + 2'h1;
            tick_cnt_q <= tick_cnt_q + 2'h1;
            if (osc_cnt_q != 2'h1) sync_pin <= sync_req;
        end
    end
endmodule : sps_ctrl_model

// ===== testbench/sps_phase_sync_sva.sv
// Port checker of the phase sync block.
`timescale 1ns/100ps
module sps_phase_sync_sva
    import sps_pkg::*;
#(parameter int ADDR_W = 8)(
    input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic              osc_edge, sync_event, modulator_reset,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata, prdata,
    input wire logic [2:0]        folded_divide,
    input wire logic [5:0]        delay_trim_one, delay_trim_two, delay_trim_three, delay_trim_four
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] trim_sum;
    logic       wr;
    assign trim_sum = 8'(delay_trim_one) + 8'(delay_trim_two) + 8'(delay_trim_three) + 8'(delay_trim_four);
    assign wr = psel && penable && pready && pwrite;
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access");
    property p_fold; folded_divide inside {3'h1, 3'h4, 3'h6}; endproperty
    a_fold: assert property (p_fold) else $error("bad folded divide");
    property p_retime; sync_event |-> $past(osc_edge) && !$past(sync_event); endproperty
    a_retime: assert property (p_retime) else $error("sync off reference edge");
    property p_sum; trim_sum == 8'h3f || trim_sum == 8'h00; endproperty
    a_sum: assert property (p_sum) else $error("trim words do not sum");
    property p_mrst; wr && paddr == ADDR_W'(SPS_OFF_CMD) && pwdata[SPS_CMD_MOD_RST] |-> ##[1:2] modulator_reset; endproperty
    a_mrst: assert property (p_mrst) else $error("no modulator reset");
    property p_inval; wr && paddr == ADDR_W'(SPS_OFF_DELAY) && pwdata[7:0] > SPS_DELAY_MAX |-> ##3 trim_sum == 8'h00; endproperty
    a_inval: assert property (p_inval) else $error("invalid delay kept trims");
    property p_min; wr && paddr == ADDR_W'(SPS_OFF_DELAY) && pwdata[7:0] == 8'h00 |-> ##3 delay_trim_one == 6'h24; endproperty
    a_min: assert property (p_min) else $error("minimum delay trims wrong");
endmodule : sps_phase_sync_sva
bind sps_phase_sync sps_phase_sync_sva #(.ADDR_W(ADDR_W)) i_sps_phase_sync_sva (.*);

// ===== testbench/sps_phase_sync_tb_top.sv
// Self-checking testbench of the phase sync block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module sps_phase_sync_tb_top import sps_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_req, sync_pin, osc_edge, output_tick;
    logic        pulse_request, sync_event, modulator_reset, pulse_out, cal_force, err, pulse_q;
    logic [7:0]  paddr, cal_capcode_in, osc_current_setting_in, cal_capcode_out, osc_current_setting_out;
    logic [31:0] pwdata, prdata, rd, modulator_seed;
    logic [2:0]  cal_core_in, cal_core_out, folded_divide;
    logic [5:0]  delay_trim_one, delay_trim_two, delay_trim_three, delay_trim_four;
    int          n_fail, check_count, cyc, sync_n, pulse_n;
    sps_phase_sync i_sps_phase_sync (.*);
    sps_ctrl_model i_sps_ctrl_model (.*);
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pulse_q <= pulse_out;
        if (sync_event === 1'h1) sync_n <= sync_n + 1;
        if (pulse_out === 1'h1 && pulse_q !== 1'h1) pulse_n <= pulse_n + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic t_regs;
        apb(1'h0, SPS_OFF_CTRL, 32'h0);
        `CHK("ctrl", SPS_CTRL_RST, rd)
        apb(1'h0, SPS_OFF_DENOM, 32'h0);
        `CHK("denom", SPS_DENOM_RST, rd)
        apb(1'h1, 8'h30, 32'hffff_ffff);
        `CHK("unmapped", 1'h1, err)
    endtask : t_regs
    task automatic t_fold;
        logic [7:0] ctl [6] = '{8'h16, 8'h12, 8'h06, 8'h26, 8'h1a, 8'h26};
        logic [7:0] dv [6] = '{8'h02, 8'h02, 8'h03, 8'h18, 8'hc0, 8'h06};
        logic [2:0] fe [6] = '{3'h1, 3'h4, 3'h6, 3'h4, 3'h1, 3'h6};
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, SPS_OFF_CTRL, {24'h0, ctl[i]});
            apb(1'h1, SPS_OFF_DIVIDE, {24'h0, dv[i]});
            repeat (2) @(posedge pclk);
            #1;
            `CHK("folded", fe[i], folded_divide)
        end
    endtask : t_fold
    task automatic t_sync;
        apb(1'h1, SPS_OFF_DIVIDE, 32'h2);
        apb(1'h1, SPS_OFF_CTRL, 32'h1001);
        repeat (12) @(posedge pclk);
        `CHK("entry", 0, sync_n)
        apb(1'h1, SPS_OFF_SEED, 32'h5);
        apb(1'h1, SPS_OFF_SEED, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("seed", 32'h7, modulator_seed)
        apb(1'h0, SPS_OFF_PHASE, 32'h0);
        `CHK("phase", 32'h30, rd)
        apb(1'h1, SPS_OFF_CMD, 32'h1);
        repeat (2) @(posedge pclk);
        apb(1'h0, SPS_OFF_PHASE, 32'h0);
        `CHK("mod reset", 32'h0, rd)
        apb(1'h1, SPS_OFF_CTRL, 32'h1002);
        apb(1'h1, SPS_OFF_CTRL, 32'h1001);
        repeat (8) @(posedge pclk);
        `CHK("soft sync", 1, sync_n)
        apb(1'h1, SPS_OFF_SEED, 32'h3);
        sync_req <= 1'h1;
        repeat (8) @(posedge pclk);
        sync_req <= 1'h0;
        `CHK("pin sync", 2, sync_n)
        apb(1'h0, SPS_OFF_PHASE, 32'h0);
        `CHK("sync phase", 32'h0, rd)
    endtask : t_sync
    task automatic t_delay;
        logic [7:0] st [8] = '{8'h00, 8'h24, 8'h64, 8'ha2, 8'ha3, 8'he1, 8'hf7, 8'hf8};
        logic [23:0] tw [8] = '{24'h91b000, 24'h03f000, 24'h000f81, 24'h00003f, 24'h04003e, 24'hfc0000,
                                24'ha56000, 24'h000000};
        for (int i = 0; i < 8; i++) begin
            apb(1'h1, SPS_OFF_DELAY, {24'h0, st[i]});
            repeat (3) @(posedge pclk);
            #1;
            `CHK("trims", tw[i], {delay_trim_one, delay_trim_two, delay_trim_three, delay_trim_four})
        end
    endtask : t_delay
    task automatic t_pulse;
        logic [31:0] ctl [3] = '{32'h03c1, 32'h00c1, 32'h03c2};
        int want [3] = '{3, 0, 0};
        int b;
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, SPS_OFF_CTRL, ctl[i]);
            b = pulse_n;
            apb(1'h1, SPS_OFF_CMD, 32'h2);
            repeat (60) @(posedge pclk);
            `CHK("pulses", want[i], pulse_n - b)
        end
        apb(1'h1, SPS_OFF_CTRL, 32'h0041);
        b = pulse_n;
        pulse_request <= 1'h1;
        repeat (64) @(posedge pclk);
        pulse_request <= 1'h0;
        repeat (12) @(posedge pclk);
        `CHK("stream", 8, pulse_n - b)
    endtask : t_pulse
    task automatic t_cal;
        apb(1'h1, SPS_OFF_CAL_FORCE, 32'h5a3c_0201);
        repeat (2) @(posedge pclk);
        #1;
        `CHK("cal", {1'h1, 3'h2, 8'h3c, 8'h5a}, {cal_force, cal_core_out, cal_capcode_out, osc_current_setting_out})
        apb(1'h0, SPS_OFF_CAL_READ, 32'h0);
        `CHK("cal read", {8'h3e, 8'ha7, 5'h0, 3'h5, 8'h0}, rd)
    endtask : t_cal
    initial begin
        {psel, penable, pwrite, sync_req, pulse_request, paddr, pwdata} = '0;
        {cal_core_in, cal_capcode_in, osc_current_setting_in} = {3'h5, 8'ha7, 8'h3e};
        presetn = 1'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_fold;
        t_sync;
        t_delay;
        t_pulse;
        t_cal;
        report_and_stop;
    end
endmodule : sps_phase_sync_tb_top
